// ---- logic/microstep_translator_decay_control.sv ----
// step/direction translator with per-bridge fixed off-time decay control
`timescale 1ns/1ns
// Notes on behaviour
// - select pins decode full to sixteenth step
// - undriven select pins read as low
// - reset loads home levels and mixed decay
// - each step rising edge advances one increment
// - translator drives DAC levels and polarities
// - falling level mixed, otherwise slow decay
// - select change applies at next step edge
// - software home or fault returns translator home
// - mixed off period: fast 31.25%, then slow
// - grounded off-time pin forces mixed always
// - grounded off-time pin gives 30us off-time
// - reset forces home and bridges off
// - step edges ignored while reset low
// - each bridge has fixed off-time current loop
// - direction sampled only at step edge
// - pin at supply: 30us, auto, full slow
// - output disable stops bridges, translator runs
module microstep_translator_decay_control
	import translator_pkg::*;
#(
	parameter logic [CNT_W-1:0] OFF_CYCLES = OFFTIME_RST
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// avalon-mm slave
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// step interface
	input wire logic i_step,
	input wire logic i_dir,
	input wire logic i_res_sel_bit0,
	input wire logic i_res_sel_bit1,
	input wire logic i_res_sel_bit2,
	input wire logic [1:0] i_offtime_config_pin,
	input wire logic i_outputs_disable,
	// faults and current sense
	input wire logic i_thermal_trip,
	input wire logic i_overcurrent_trip,
	input wire logic i_supply_lockout,
	input wire logic [1:0] i_sense_trip,
	// bridge drive
	output logic [LVL_W-1:0] o_dac_level1,
	output logic [LVL_W-1:0] o_dac_level2,
	output logic [1:0] o_polarity,
	output logic [1:0] o_decay_mixed,
	output logic [1:0] o_bridge_drive,
	output logic [1:0] o_fast_decay,
	output logic o_home
);

	typedef struct packed {
		logic [2:0] step_s;
		logic [1:0] dir_s;
		logic [5:0] sel_s;
		logic [3:0] cfg_s;
		logic [1:0] dis_s;
		logic [3:0] trip_s;
		logic [1:0] flt_s;
		logic [IDX_W-1:0] idx;
		logic full_res;
		logic [1:0] mixed;
		phase_t [1:0] ph;
		logic [1:0][CNT_W-1:0] cnt;
		logic [1:0] drive;
		logic [1:0] fast;
		logic [LVL_W-1:0] lvl1;
		logic [LVL_W-1:0] lvl2;
		logic [1:0] pol;
		logic ack;
		logic [31:0] rdata;
		logic soft_home;
		logic [CNT_W-1:0] offtime;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic rst_meta_r;
	logic rst_sync_r;
	logic rst_n;

	// quarter-wave current levels in percent of full scale
	function automatic logic [LVL_W-1:0] qlevel(input logic [4:0] k);
		logic [LVL_W-1:0] v;
		v = 7'h00;
		unique case (k)
			5'h00: v = 7'h00;
			5'h01: v = 7'h0A;
			5'h02: v = 7'h14;
			5'h03: v = 7'h1D;
			5'h04: v = 7'h26;
			5'h05: v = 7'h2F;
			5'h06: v = 7'h38;
			5'h07: v = 7'h3F;
			5'h08: v = 7'h47;
			5'h09: v = 7'h4D;
			5'h0A: v = 7'h53;
			5'h0B: v = 7'h58;
			5'h0C: v = 7'h5C;
			5'h0D: v = 7'h60;
			5'h0E: v = 7'h62;
			5'h0F: v = 7'h63;
			default: v = 7'h64;
		endcase
		return v;
	endfunction

	// sine of the index: level magnitude and negative flag
	function automatic logic [LVL_W:0] wave(input logic [IDX_W-1:0] i);
		logic [4:0] k;
		k = i[4] ? 5'(5'h10 - {1'b0, i[3:0]}) : {1'b0, i[3:0]};
		return {i[5] && (k != 5'h00), qlevel(k)};
	endfunction

	// reset: asserted at once, released on the clock
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	assign rst_n = rst_sync_r;

	always_comb begin
		logic step_rise;
		logic go_home;
		logic [2:0] sel;
		logic [IDX_W-1:0] inc;
		logic [IDX_W-1:0] nidx;
		logic [LVL_W:0] w1;
		logic [LVL_W:0] w2;
		logic [1:0] cfg;
		logic [CNT_W-1:0] off_len;
		logic [CNT_W+2:0] fast_prod;
		logic [CNT_W-1:0] fast_len;
		step_rise = 1'b0;
		go_home = 1'b0;
		sel = 3'h0;
		inc = 6'h00;
		nidx = 6'h00;
		w1 = 8'h00;
		w2 = 8'h00;
		cfg = 2'h0;
		off_len = 16'h0000;
		fast_prod = 19'h00000;
		fast_len = 16'h0000;
		st_nxt = st_r;
		st_nxt.step_s = {st_r.step_s[1:0], i_step};
		st_nxt.dir_s = {st_r.dir_s[0], i_dir};
		st_nxt.sel_s = {st_r.sel_s[2:0],
			i_res_sel_bit2, i_res_sel_bit1, i_res_sel_bit0};
		st_nxt.cfg_s = {st_r.cfg_s[1:0], i_offtime_config_pin};
		st_nxt.dis_s = {st_r.dis_s[0], i_outputs_disable};
		st_nxt.trip_s = {st_r.trip_s[1:0], i_sense_trip};
		st_nxt.flt_s = {st_r.flt_s[0],
			i_thermal_trip | i_overcurrent_trip | i_supply_lockout};
		// edge found on the synchronised step only
		step_rise = st_r.step_s[1] && !st_r.step_s[2];
		// faults and software home the translator
		go_home = st_r.flt_s[1] || st_r.soft_home;
		sel = st_r.sel_s[5:3];
		cfg = st_r.cfg_s[3:2];
		// resolution decode; floating pins already read low
		unique case (sel)
			3'b001: inc = 6'h08;
			3'b010: inc = 6'h04;
			3'b011: inc = 6'h02;
			3'b111: inc = 6'h01;
			default: inc = QUARTER;
		endcase
		// direction used only on the step edge
		// six-bit index wraps on its own in both directions
		nidx = st_r.dir_s[1] ? st_r.idx + inc : st_r.idx - inc;
		st_nxt.soft_home = 1'b0;
		if (go_home) begin
			// home position shared by every resolution
			st_nxt.idx = HOME_IDX;
			st_nxt.mixed = 2'b11;
		end else if (step_rise) begin
			st_nxt.idx = nidx;
			st_nxt.full_res = (sel == 3'b000);
		end
		// cosine on bridge 1, sine on bridge 2
		w1 = wave(IDX_W'(st_nxt.idx + QUARTER));
		w2 = wave(st_nxt.idx);
		st_nxt.lvl1 = w1[LVL_W-1:0];
		st_nxt.lvl2 = w2[LVL_W-1:0];
		st_nxt.pol = {w2[LVL_W], w1[LVL_W]};
		if (step_rise && !go_home) begin
			if (cfg == OFFCFG_GND) begin
				// grounded pin: mixed on every off period
				st_nxt.mixed = 2'b11;
			end else if (cfg == OFFCFG_VDD && sel == 3'b000) begin
				// full step at supply setting uses slow
				st_nxt.mixed = 2'b00;
			end else begin
				st_nxt.mixed[0] = w1[LVL_W-1:0] < st_r.lvl1;
				st_nxt.mixed[1] = w2[LVL_W-1:0] < st_r.lvl2;
			end
		end
		// internal off-time unless a resistor sets it
		off_len = (cfg == OFFCFG_RES) ? st_r.offtime : OFF_CYCLES;
		fast_prod = (CNT_W+3)'(off_len) * (CNT_W+3)'(FAST_NUM);
		fast_len = CNT_W'(fast_prod >> FAST_SHIFT);
		for (int b = 0; b < 2; b++) begin
			st_nxt.cnt[b] = st_r.cnt[b] + 16'h0001;
			unique case (st_r.ph[b])
				PH_ON: begin
					if (st_r.cnt[b] >= BLANK_CNT && st_r.trip_s[2+b]) begin
						st_nxt.ph[b] = st_r.mixed[b] ? PH_FAST : PH_SLOW;
						st_nxt.cnt[b] = 16'h0000;
					end else if (st_r.cnt[b] >= BLANK_CNT) begin
						st_nxt.cnt[b] = BLANK_CNT;
					end
				end
				PH_FAST: begin
					// fast part then slow for the rest
					if (st_r.cnt[b] + 16'h0001 >= fast_len) begin
						st_nxt.ph[b] = PH_SLOW;
					end
				end
				PH_SLOW: begin
					if (st_r.cnt[b] + 16'h0001 >= off_len) begin
						st_nxt.ph[b] = PH_ON;
						st_nxt.cnt[b] = 16'h0000;
					end
				end
				default: begin
					st_nxt.ph[b] = PH_ON;
					st_nxt.cnt[b] = 16'h0000;
				end
			endcase
			// disable stops drive, sequencing carries on
			st_nxt.drive[b] = (st_nxt.ph[b] == PH_ON)
				&& !st_r.dis_s[1] && !st_r.flt_s[1];
			st_nxt.fast[b] = (st_nxt.ph[b] == PH_FAST)
				&& !st_r.dis_s[1] && !st_r.flt_s[1];
		end
		// bus slave: one wait state, write lands on the ack edge
		st_nxt.ack = (i_avs_read || i_avs_write) && !st_r.ack;
		if (i_avs_read && !st_r.ack) begin
			unique case (i_avs_address)
				REG_CTRL: st_nxt.rdata = 32'h0000_0000;
				REG_OFFTIME: st_nxt.rdata = {16'h0000, st_r.offtime};
				REG_STATUS: st_nxt.rdata = {11'h000, st_r.ph[1],
					st_r.ph[0], st_r.mixed, st_r.full_res,
					st_r.dir_s[1], sel, 2'h0, st_r.idx};
				REG_LEVELS: st_nxt.rdata = {14'h0000, st_r.pol,
					1'b0, st_r.lvl2, 1'b0, st_r.lvl1};
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (i_avs_write && st_r.ack) begin
			unique case (i_avs_address)
				REG_CTRL: st_nxt.soft_home = i_avs_writedata[CTRL_HOME_BIT];
				REG_OFFTIME: st_nxt.offtime = i_avs_writedata[CNT_W-1:0];
				default: st_nxt.offtime = st_r.offtime;
			endcase
		end
	end

	// reset holds home, mixed decay, bridges off
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.idx <= HOME_IDX;
			st_r.mixed <= 2'b11;
			st_r.ph[0] <= PH_ON;
			st_r.ph[1] <= PH_ON;
			st_r.lvl1 <= 7'h47;
			st_r.lvl2 <= 7'h47;
			st_r.offtime <= OFF_CYCLES;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st_r.ack;
	assign o_avs_readdata = st_r.rdata;
	assign o_dac_level1 = st_r.lvl1;
	assign o_dac_level2 = st_r.lvl2;
	assign o_polarity = st_r.pol;
	assign o_decay_mixed = st_r.mixed;
	assign o_bridge_drive = st_r.drive;
	assign o_fast_decay = st_r.fast;
	assign o_home = (st_r.idx == HOME_IDX);

	sequence s_step_edge;
		st_r.step_s[1] && !st_r.step_s[2];
	endsequence

	// step edge moves the index off its previous value
	a_step_advance: assert property (@(posedge i_mclk) disable iff (!rst_n)
		s_step_edge and (!st_r.flt_s[1] && !st_r.soft_home)
		|=> st_r.idx != $past(st_r.idx)) else $error("step did not advance");
	a_idx_stable: assert property (@(posedge i_mclk) disable iff (!rst_n)
		!(st_r.step_s[1] && !st_r.step_s[2]) && !st_r.flt_s[1]
		&& !st_r.soft_home |=> $stable(st_r.idx))
		else $error("index moved without a step edge");
	a_fault_home: assert property (@(posedge i_mclk) disable iff (!rst_n)
		st_r.flt_s[1] |=> st_r.idx == HOME_IDX && !st_r.drive[0]
		&& !st_r.drive[1]) else $error("fault did not home");
	a_disable_off: assert property (@(posedge i_mclk) disable iff (!rst_n)
		st_r.dis_s[1] |=> st_r.drive == 2'b00 && st_r.fast == 2'b00)
		else $error("bridge driven while disabled");
	// grounded pin makes mixed decay after a step
	a_gnd_mixed: assert property (@(posedge i_mclk) disable iff (!rst_n)
		s_step_edge and (st_r.cfg_s[3:2] == OFFCFG_GND)
		|=> st_r.mixed == 2'b11) else $error("grounded pin not mixed");
	// rising or equal level gives slow decay on bridge 1
	a_auto_slow: assert property (@(posedge i_mclk) disable iff (!rst_n)
		##1 $changed(st_r.idx) && st_r.cfg_s[3:2] == OFFCFG_RES
		&& st_r.lvl1 >= $past(st_r.lvl1) && !$past(st_r.flt_s[1])
		&& !$past(st_r.soft_home) |-> !st_r.mixed[0])
		else $error("slow decay expected");
	a_mixed_fast: assert property (@(posedge i_mclk) disable iff (!rst_n)
		st_r.ph[0] == PH_ON && st_r.cnt[0] >= BLANK_CNT
		&& st_r.trip_s[2] && st_r.mixed[0] |=> st_r.ph[0] == PH_FAST)
		else $error("mixed trip skipped fast decay");
	a_blank_hold: assert property (@(posedge i_mclk) disable iff (!rst_n)
		st_r.ph[0] == PH_ON && st_r.cnt[0] < BLANK_CNT
		|=> st_r.ph[0] == PH_ON) else $error("trip taken during blanking");
	// home levels are equal on both bridges
	a_home_levels: assert property (@(posedge i_mclk) disable iff (!rst_n)
		st_r.idx == HOME_IDX |-> st_r.lvl1 == st_r.lvl2 && st_r.pol == 2'b00)
		else $error("home levels wrong");

endmodule // microstep_translator_decay_control

// ---- logic/translator_pkg.sv ----
// constants and types shared by the microstep translator design
package translator_pkg;
	// timebase
	localparam int CLK_MHZ = 250;
	localparam int OFF_TIME_US = 30;
	localparam int OFF_CYC = OFF_TIME_US * CLK_MHZ;
	localparam int BLANK_NS = 1000;
	localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] BLANK_CNT = CNT_W'(BLANK_CYC - 1);
	// fast part of a mixed off period is 5/16 = 31.25 %
	localparam int FAST_NUM = 5;
	localparam int FAST_SHIFT = 4;
	// translator index: 64 sixteenth steps per electrical cycle
	localparam int IDX_W = 6;
	localparam int LVL_W = 7;
	localparam logic [IDX_W-1:0] HOME_IDX = 6'h08;
	localparam logic [IDX_W-1:0] QUARTER = 6'h10;
	// off-time configuration pin states
	localparam logic [1:0] OFFCFG_VDD = 2'h0;
	localparam logic [1:0] OFFCFG_GND = 2'h1;
	localparam logic [1:0] OFFCFG_RES = 2'h2;
	// register byte addresses
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_OFFTIME = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_LEVELS = 4'hC;
	localparam int CTRL_HOME_BIT = 0;
	localparam logic [CNT_W-1:0] OFFTIME_RST = CNT_W'(OFF_CYC);
	// pwm phase of one bridge
	typedef enum logic [2:0] {
		PH_ON = 3'b001,
		PH_FAST = 3'b010,
		PH_SLOW = 3'b100
	} phase_t;
endpackage

// ---- test/step_source.sv ----
// partner model: controller driving step, direction and resolution select
`timescale 1ns/1ns
module step_source #(
	parameter int SETUP_CYC = 50,
	parameter int HIGH_CYC = 250,
	parameter int LOW_CYC = 250
) (
	input wire logic i_mclk,
	input wire logic i_go,
	input wire logic i_pulse,
	input wire logic i_dir_req,
	input wire logic [2:0] i_sel_req,
	output logic o_busy = 1'b0,
	output logic o_step = 1'b0,
	output logic o_dir = 1'b1,
	output logic [2:0] o_sel = 3'h7
);
	int cnt_r = 0;
	logic pulse_r = 1'b0;
	always @(posedge i_mclk) begin
		if (i_go && !o_busy) begin
			o_dir <= i_dir_req;
			o_sel <= i_sel_req;
			pulse_r <= i_pulse;
			o_busy <= 1'b1;
			cnt_r <= 0;
		end else if (o_busy) begin
			cnt_r <= cnt_r + 1;
			o_step <= pulse_r && cnt_r >= SETUP_CYC
				&& cnt_r < SETUP_CYC + HIGH_CYC;
			if (!pulse_r || cnt_r == SETUP_CYC + HIGH_CYC + LOW_CYC)
				o_busy <= 1'b0;
		end
	end
endmodule // step_source

// ---- test/microstep_translator_decay_control_tb.sv ----
// bench for the translator: bus, stepping, decay and faults
`timescale 1ns/1ns
module microstep_translator_decay_control_tb;
	import translator_pkg::*;
	logic clk = 0;
	logic rst_n = 0;
	logic [3:0] adr = 4'h0;
	logic rd = 0;
	logic wr = 0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic waitreq;
	logic go = 0;
	logic pls = 0;
	logic dreq = 1;
	logic [2:0] sreq = 3'h7;
	logic busy, stp, dir;
	logic [2:0] sel;
	logic [1:0] pin = OFFCFG_VDD;
	logic dis = 0;
	logic therm = 0;
	logic [1:0] sense = 2'h0;
	logic [LVL_W-1:0] lvl1, lvl2;
	logic [1:0] pol, mixed, drive, fast;
	logic home;
	logic [31:0] r;
	int failures = 0;
	int checks_done = 0;
	int n;
	int exp_idx;
	logic [2:0] sreq_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	int inc_tab [5] = '{16, 8, 4, 2, 1};
	always #2 clk = ~clk;
	microstep_translator_decay_control #(.OFF_CYCLES(16'h0028))
		microstep_translator_decay_control_inst (.i_mclk(clk),
		.i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
		.o_avs_waitrequest(waitreq), .i_step(stp), .i_dir(dir),
		.i_res_sel_bit0(sel[0]), .i_res_sel_bit1(sel[1]),
		.i_res_sel_bit2(sel[2]), .i_offtime_config_pin(pin),
		.i_outputs_disable(dis), .i_thermal_trip(therm),
		.i_overcurrent_trip(1'b0), .i_supply_lockout(1'b0),
		.i_sense_trip(sense), .o_dac_level1(lvl1), .o_dac_level2(lvl2),
		.o_polarity(pol), .o_decay_mixed(mixed), .o_bridge_drive(drive),
		.o_fast_decay(fast), .o_home(home));
	step_source step_source_inst (.i_mclk(clk), .i_go(go), .i_pulse(pls),
		.i_dir_req(dreq), .i_sel_req(sreq), .o_busy(busy), .o_step(stp),
		.o_dir(dir), .o_sel(sel));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic hang(string nm);
		failures++;
		$display("MISMATCH %s expected done seen timeout", nm);
		tally_and_finish();
	endtask
	// one avalon access, held until waitrequest is seen low at an edge
	task automatic xfer(logic w, logic [3:0] a, logic [31:0] d);
		logic ws;
		n = 0;
		// one idle edge so a back-to-back call never re-drives at once
		@(posedge clk);
		adr <= a;
		wdat <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clk);
			ws = waitreq;
			r = rdat;
			n++;
		end while (ws !== 1'b0 && n < 50);
		if (ws !== 1'b0)
			hang("bus");
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic step(logic p, logic d, logic [2:0] s);
		pls <= p;
		dreq <= d;
		sreq <= s;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (busy !== 1'b0 && n < 2000);
		if (busy !== 1'b0)
			hang("step");
	endtask
	task automatic idx_is(int e);
		xfer(1'b0, REG_STATUS, 32'h0);
		chk("index", r[5:0], e[5:0]);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		// no sleep input: only let reset settle before stepping
		repeat (3) @(posedge clk);
		chk("home mixed", {home, mixed, drive, pol}, 7'h70);
		xfer(1'b0, REG_LEVELS, 32'h0);
		chk("levels", r, 32'h0000_4747);
		xfer(1'b0, REG_OFFTIME, 32'h0);
		chk("offtime", r, 32'h0000_0028);
		xfer(1'b0, 4'h2, 32'h0);
		chk("unmapped", r, 32'h0);
		step(1'b1, 1'b1, 3'h7);
		idx_is(9);
		chk("auto decay", mixed, 2'h1);
		chk("levels out", {pol, lvl2, lvl1}, {2'h0, 7'h4D, 7'h3F});
		$display("test reset and first step done");
		xfer(1'b1, REG_CTRL, 32'h1);
		exp_idx = 8;
		// every resolution in turn, full step down to sixteenth
		foreach (sreq_tab[k]) begin
			step(1'b1, 1'b1, sreq_tab[k]);
			exp_idx += inc_tab[k];
			idx_is(exp_idx);
		end
		step(1'b0, 1'b0, 3'h0);
		idx_is(exp_idx);
		step(1'b1, 1'b0, 3'h0);
		idx_is(exp_idx - 16);
		$display("test resolutions done");
		xfer(1'b1, REG_CTRL, 32'h1);
		step(1'b1, 1'b0, 3'h0);
		idx_is(56);
		chk("full slow", mixed, 2'h0);
		chk("polarity", pol, 2'h2);
		xfer(1'b1, REG_OFFTIME, 32'h30);
		xfer(1'b0, REG_OFFTIME, 32'h0);
		chk("offtime set", r, 32'h0000_0030);
		pin <= OFFCFG_RES;
		step(1'b1, 1'b1, 3'h7);
		idx_is(57);
		chk("auto res", mixed, 2'h2);
		pin <= OFFCFG_GND;
		step(1'b1, 1'b1, 3'h7);
		chk("gnd mixed", mixed, 2'h3);
		n = 0;
		while (drive[0] !== 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		if (drive[0] !== 1'b1)
			hang("drive");
		repeat (260) @(posedge clk);
		sense <= 2'h3;
		n = 0;
		while (fast[0] !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (fast[0] !== 1'b1)
			hang("fast");
		n = 0;
		while (fast[0] === 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		sense <= 2'h0;
		chk("fast cycles", n, 32'd12);
		$display("test decay done");
		dis <= 1'b1;
		step(1'b1, 1'b1, 3'h7);
		idx_is(59);
		chk("disabled", drive, 2'h0);
		dis <= 1'b0;
		therm <= 1'b1;
		repeat (5) @(posedge clk);
		chk("fault home", {home, mixed, drive}, 5'h1C);
		therm <= 1'b0;
		rst_n <= 1'b0;
		step(1'b1, 1'b1, 3'h7);
		chk("reset home", {home, drive}, 3'h4);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		idx_is(8);
		$display("test faults and reset done");
		tally_and_finish();
	end
endmodule // microstep_translator_decay_control_tb
